// *** dda_channel.sv ***
// Dual-address DMA channel with Wishbone register slave
`include "dda_regs.svh"

// Notes on behaviour
// - Operand read into holding register, then written
// - Each phase up to four bus cycles
// - Internal, burst or cycle-steal request start
// - Read uses source pointer, code, size
// - Read data captured when cycle ends
// - Source pointer steps after whole operand
// - Source requester gets acknowledge in read
// - Cycle steal needs two consecutive high clocks
// - Done input marks final transfer in external mode
// - Write uses destination pointer, code, size
// - Destination pointer steps after whole operand
// - Count drops by bytes moved
// - Zero count sets done flag, and the pin in external mode
// - Destination requester gets acknowledge in write
// - Own bus request and grant handshake
// - Phases run as normal read, write cycles
// - Top code line held across whole operand
// - Internal mode arbitrates once start set
// - External mode waits for start and request
// - Cycle steal: one operand per request, status at end
// - Burst request gone means bus released
// - Early steal pulses ignored, else release
// - Both phases finish unless bus error
// - Stop on zero, done, start clear, error
module dda_channel (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        wbCyc,
    input  wire logic        wbStb,
    input  wire logic        wbWe,
    input  wire logic [7:0]  wbAdr,
    input  wire logic [3:0]  wbSel,
    input  wire logic [31:0] wbDatIn,
    output logic             wbAck,
    output logic [31:0]      wbDatOut,
    output logic             busRequest,
    input  wire logic        busGrant,
    output logic             busGrantAck,
    output logic             sysStb,
    output logic             sysRnw,
    output logic [31:0]      sysAdr,
    output logic [31:0]      sysDatOut,
    input  wire logic [31:0] sysDatIn,
    output logic [2:0]       sysSize,
    output logic [2:0]       sysFc,
    output logic             topFunctionCodeLine,
    input  wire logic        sysAck,
    input  wire logic        sysBerr,
    input  wire logic        transferRequestLine,
    output logic             transferAcknowledgeLine,
    input  wire logic        doneHandshakeIn,
    output logic             doneHandshakeOut
);
    dda_pkg::dda_core_t st_reg;
    dda_pkg::dda_core_t st_next;

    logic       reqLvl;
    logic       reqPulse;
    logic       doneLvl;
    logic [2:0] ssz;
    logic [2:0] dsz;
    logic [2:0] opB;
    logic       run;
    logic       ext;
    logic       steal;
    logic       srcReq;
    logic       reqNow;
    logic [2:0] rdNext;
    logic [2:0] wrNext;
    logic       rdEnd;
    logic       wrEnd;

    dda_sync u_req_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .pinIn    (transferRequestLine),
        .levelOut (reqLvl)
    );

    dda_sync u_done_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .pinIn    (doneHandshakeIn),
        .levelOut (doneLvl)
    );

    dda_req_detect u_steal (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .levelIn  (reqLvl),
        .pulseOut (reqPulse)
    );

    function automatic logic [2:0] szBytes(input logic [1:0] code);
        case (code)
            `DDA_SZ_BYTE: szBytes = `DDA_BYTES_1;
            `DDA_SZ_WORD: szBytes = `DDA_BYTES_2;
            default:      szBytes = `DDA_BYTES_4;
        endcase
    endfunction

    function automatic logic [31:0] byteMask(input logic [2:0] nb);
        case (nb)
            `DDA_BYTES_1: byteMask = `DDA_MASK_1;
            `DDA_BYTES_2: byteMask = `DDA_MASK_2;
            default:      byteMask = `DDA_MASK_4;
        endcase
    endfunction

    function automatic logic [31:0] mergeSel(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  sel);
        mergeSel = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                mergeSel[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
    endfunction

    assign ssz    = szBytes(st_reg.ctrl[`DDA_CTL_SSZ_HI:`DDA_CTL_SSZ_LO]);
    assign dsz    = szBytes(st_reg.ctrl[`DDA_CTL_DSZ_HI:`DDA_CTL_DSZ_LO]);
    // Operand is the larger of the two sizes
    assign opB    = (ssz > dsz) ? ssz : dsz;
    assign ext    = st_reg.ctrl[`DDA_CTL_EXT];
    assign steal  = st_reg.ctrl[`DDA_CTL_STEAL];
    assign srcReq = st_reg.ctrl[`DDA_CTL_SRCREQ];
    assign run    = st_reg.ctrl[`DDA_CTL_START] & ~st_reg.done
                    & ~st_reg.errSrc & ~st_reg.errDst;
    // Burst follows the level, cycle steal a latched pulse
    assign reqNow = ~ext | (steal ? st_reg.pending : reqLvl);
    assign rdNext = st_reg.off + ssz;
    assign wrNext = st_reg.off + dsz;
    assign rdEnd  = (st_reg.state == dda_pkg::DDA_READ) & sysAck
                    & ~sysBerr & (rdNext >= opB);
    assign wrEnd  = (st_reg.state == dda_pkg::DDA_WRITE) & sysAck
                    & ~sysBerr & (wrNext >= opB);

    always_comb begin
        logic [2:0]  pos;
        logic [31:0] msk;
        logic        inOp;
        pos  = `DDA_ZERO_OFF;
        msk  = `DDA_ZERO_32;
        inOp = 1'b0;
        st_next = st_reg;

        // Register slave: one-cycle answer, unmapped reads give zero
        st_next.wbAck = wbCyc & wbStb & ~st_reg.wbAck;
        st_next.wbDat = `DDA_ZERO_32;
        if (wbCyc & wbStb & ~st_reg.wbAck) begin
            if (!wbWe) begin
                if (wbAdr == `DDA_OFS_CTRL) begin
                    st_next.wbDat[`DDA_CTL_HI:0] = st_reg.ctrl;
                end else if (wbAdr == `DDA_OFS_STATUS) begin
                    st_next.wbDat[`DDA_ST_DONE]   = st_reg.done;
                    st_next.wbDat[`DDA_ST_ERRSRC] = st_reg.errSrc;
                    st_next.wbDat[`DDA_ST_ERRDST] = st_reg.errDst;
                end else if (wbAdr == `DDA_OFS_SRC) begin
                    st_next.wbDat = st_reg.srcPtr;
                end else if (wbAdr == `DDA_OFS_DST) begin
                    st_next.wbDat = st_reg.dstPtr;
                end else if (wbAdr == `DDA_OFS_COUNT) begin
                    st_next.wbDat[23:0] = st_reg.count;
                end else if (wbAdr == `DDA_OFS_FC) begin
                    st_next.wbDat[7:0] = st_reg.function_code_register;
                end
            end else begin
                if (wbAdr == `DDA_OFS_CTRL) begin
                    // Takes effect at once, even mid-transfer
                    st_next.ctrl = 10'(mergeSel({22'h00_0000, st_reg.ctrl},
                                                wbDatIn, wbSel));
                end else if (wbAdr == `DDA_OFS_STATUS) begin
                    if (wbSel[0]) begin
                        st_next.done   = st_reg.done
                                         & ~wbDatIn[`DDA_ST_DONE];
                        st_next.errSrc = st_reg.errSrc
                                         & ~wbDatIn[`DDA_ST_ERRSRC];
                        st_next.errDst = st_reg.errDst
                                         & ~wbDatIn[`DDA_ST_ERRDST];
                    end
                end else if (wbAdr == `DDA_OFS_SRC) begin
                    st_next.srcPtr = mergeSel(st_reg.srcPtr, wbDatIn, wbSel);
                end else if (wbAdr == `DDA_OFS_DST) begin
                    st_next.dstPtr = mergeSel(st_reg.dstPtr, wbDatIn, wbSel);
                end else if (wbAdr == `DDA_OFS_COUNT) begin
                    st_next.count = 24'(mergeSel({8'h00, st_reg.count},
                                                 wbDatIn, wbSel));
                end else if (wbAdr == `DDA_OFS_FC) begin
                    st_next.function_code_register = 8'(mergeSel({24'h00_0000, st_reg.function_code_register},
                                              wbDatIn, wbSel));
                end
            end
        end

        inOp = (st_reg.state == dda_pkg::DDA_READ)
               | (st_reg.state == dda_pkg::DDA_WRITE);
        if (ext & inOp & doneLvl) begin
            st_next.lastFlag = 1'b1;
        end

        // Engine runs after the slave so its sets win over clears
        case (st_reg.state)
            dda_pkg::DDA_IDLE: begin
                st_next.off      = `DDA_ZERO_OFF;
                st_next.lastFlag = 1'b0;
                if (run & reqNow) begin
                    st_next.state = dda_pkg::DDA_ARB;
                end
            end
            dda_pkg::DDA_ARB: begin
                if (!run) begin
                    st_next.state = dda_pkg::DDA_IDLE;
                end else if (busGrant) begin
                    st_next.state = dda_pkg::DDA_READ;
                    if (srcReq) begin
                        st_next.pending = 1'b0;
                    end
                end
            end
            dda_pkg::DDA_READ: begin
                if (sysBerr) begin
                    st_next.errSrc = 1'b1;
                    st_next.state  = dda_pkg::DDA_IDLE;
                end else if (sysAck) begin
                    // Big-endian packing: first piece lands highest
                    pos = opB - st_reg.off - ssz;
                    msk = byteMask(ssz) << {pos, 3'b000};
                    st_next.hold = (st_reg.hold & ~msk)
                        | ((sysDatIn << {pos, 3'b000}) & msk);
                    if (rdEnd) begin
                        st_next.off   = `DDA_ZERO_OFF;
                        st_next.state = dda_pkg::DDA_WRITE;
                        if (st_reg.ctrl[`DDA_CTL_SINC]) begin
                            st_next.srcPtr = st_reg.srcPtr
                                + {29'h0000_0000, opB};
                        end
                        if (!srcReq) begin
                            st_next.pending = 1'b0;
                        end
                    end else begin
                        st_next.off = rdNext;
                    end
                end
            end
            dda_pkg::DDA_WRITE: begin
                if (sysBerr) begin
                    st_next.errDst = 1'b1;
                    st_next.state  = dda_pkg::DDA_IDLE;
                end else if (sysAck) begin
                    if (wrEnd) begin
                        st_next.off = `DDA_ZERO_OFF;
                        if (st_reg.ctrl[`DDA_CTL_DINC]) begin
                            st_next.dstPtr = st_reg.dstPtr
                                + {29'h0000_0000, opB};
                        end
                        st_next.count = st_reg.count
                            - {21'h00_0000, opB};
                        if (st_reg.count <= {21'h00_0000, opB}
                            || st_reg.lastFlag) begin
                            st_next.done  = 1'b1;
                            st_next.state = dda_pkg::DDA_IDLE;
                        end else if (!st_reg.ctrl[`DDA_CTL_START]) begin
                            st_next.state = dda_pkg::DDA_IDLE;
                        end else if (reqNow) begin
                            // Bus kept; next operand starts at once
                            st_next.state = dda_pkg::DDA_READ;
                            if (srcReq) begin
                                st_next.pending = 1'b0;
                            end
                        end else begin
                            st_next.state = dda_pkg::DDA_IDLE;
                        end
                    end else begin
                        st_next.off = wrNext;
                    end
                end
            end
            default: begin
                st_next.state = dda_pkg::DDA_IDLE;
            end
        endcase

        // Pulses seen while one is still pending are dropped
        if (reqPulse & run & steal & ~st_reg.pending) begin
            st_next.pending = 1'b1;
        end

        inOp = (st_next.state == dda_pkg::DDA_READ)
               | (st_next.state == dda_pkg::DDA_WRITE);
        st_next.busReq      = st_next.state == dda_pkg::DDA_ARB;
        st_next.busGrantAck = inOp;
        st_next.stb         = inOp;
        st_next.rnw         = st_next.state == dda_pkg::DDA_READ;
        st_next.topFc       = inOp;
        if (st_next.state == dda_pkg::DDA_READ) begin
            st_next.adr = st_next.srcPtr
                + (st_reg.ctrl[`DDA_CTL_SINC] ? {29'h0000_0000, st_next.off}
                                              : `DDA_ZERO_32);
            st_next.sz   = ssz;
            st_next.fc   = st_reg.function_code_register[2:0];
            st_next.dout = `DDA_ZERO_32;
        end else begin
            st_next.adr = st_next.dstPtr
                + (st_reg.ctrl[`DDA_CTL_DINC] ? {29'h0000_0000, st_next.off}
                                              : `DDA_ZERO_32);
            st_next.sz  = dsz;
            st_next.fc  = st_reg.function_code_register[6:4];
            pos = opB - st_next.off - dsz;
            st_next.dout = inOp ? ((st_next.hold >> {pos, 3'b000})
                                   & byteMask(dsz)) : `DDA_ZERO_32;
        end
        st_next.xack = ext & ((st_next.state == dda_pkg::DDA_READ & srcReq)
            | (st_next.state == dda_pkg::DDA_WRITE & ~srcReq));
        st_next.xdone = st_next.xack & ((st_next.count
            <= {21'h00_0000, opB}) | st_next.lastFlag);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign wbAck                   = st_reg.wbAck;
    assign wbDatOut                = st_reg.wbDat;
    assign busRequest              = st_reg.busReq;
    assign busGrantAck             = st_reg.busGrantAck;
    assign sysStb                  = st_reg.stb;
    assign sysRnw                  = st_reg.rnw;
    assign sysAdr                  = st_reg.adr;
    assign sysDatOut               = st_reg.dout;
    assign sysSize                 = st_reg.sz;
    assign sysFc                   = st_reg.fc;
    assign topFunctionCodeLine     = st_reg.topFc;
    assign transferAcknowledgeLine = st_reg.xack;
    assign doneHandshakeOut        = st_reg.xdone;

    // Checks
    logic [2:0] rdCycles;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdCycles <= `DDA_ZERO_OFF;
        end else if (st_reg.state != dda_pkg::DDA_READ) begin
            rdCycles <= `DDA_ZERO_OFF;
        end else if (sysAck) begin
            rdCycles <= rdCycles + 3'h1;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence s_read_end;
        rdEnd;
    endsequence
    sequence s_write_end;
        wrEnd;
    endsequence

    a_read_then_write: assert property (s_read_end |=> sysStb && !sysRnw)
        else $error("write phase did not follow read");
    a_read_cycle_max: assert property (rdCycles <= `DDA_MAX_CYCLES)
        else $error("read phase longer than four cycles");
    a_src_code_size: assert property (sysStb && sysRnw |->
        sysFc == st_reg.function_code_register[2:0] && sysSize == ssz)
        else $error("read cycle code or size wrong");
    a_hold_capture: assert property (s_read_end and (ssz == `DDA_BYTES_4)
        |=> st_reg.hold == $past(sysDatIn))
        else $error("read data not captured");
    a_src_step: assert property (s_read_end and st_reg.ctrl[`DDA_CTL_SINC]
        |=> st_reg.srcPtr == $past(st_reg.srcPtr) + 32'($past(opB)))
        else $error("source pointer step wrong");
    a_ack_phase: assert property (transferAcknowledgeLine |->
        ext && (sysRnw == srcReq) && sysStb)
        else $error("acknowledge in wrong phase");
    a_steal_two: assert property (reqPulse |-> $past(reqLvl, 2)
        && $past(reqLvl))
        else $error("steal request taken too early");
    a_count_drop: assert property (s_write_end |=> st_reg.count
        == $past(st_reg.count) - 24'($past(opB)))
        else $error("byte count not reduced");
    a_done_set: assert property (s_write_end and (st_reg.count == 24'(opB))
        |=> st_reg.done && !sysStb)
        else $error("done flag not set at zero");
    a_internal_arb: assert property (st_reg.state == dda_pkg::DDA_IDLE
        && run && !ext |=> ##1 busRequest)
        else $error("internal start did not arbitrate");
    a_ext_wait: assert property (st_reg.state == dda_pkg::DDA_IDLE && ext
        && !steal && !reqLvl |=> !busRequest)
        else $error("arbitrated without request");
    a_grant_owns: assert property (busRequest && busGrant && run
        |=> busGrantAck && sysStb && sysRnw)
        else $error("grant not followed by bus cycle");
endmodule

// *** dda_peer.sv ***
// Bus arbiter and slave model standing on the far side of the channel
module dda_peer (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       sysStb,
    input  wire logic       busRequest,
    input  wire logic       busGrantAck,
    input  wire logic [1:0] slow,
    output logic            busGrant,
    output logic            sysAck
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] waitCnt;
    // Grant follows request, held while the channel owns the bus
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busGrant <= 1'b0;
            sysAck   <= 1'b0;
            waitCnt  <= 2'h0;
        end else begin
            busGrant <= busRequest | busGrantAck;
            sysAck   <= 1'b0;
            // Wait states vary so no fixed answer time can be relied on
            if (sysStb && !sysAck) begin
                if (waitCnt == slow) begin
                    sysAck  <= 1'b1;
                    waitCnt <= 2'h0;
                end else begin
                    waitCnt <= waitCnt + 2'h1;
                end
            end
        end
    end
endmodule

// *** dda_pkg.sv ***
// Types shared by the DMA channel modules
package dda_pkg;
    typedef enum logic [1:0] {
        DDA_IDLE  = 2'b00,
        DDA_ARB   = 2'b01,
        DDA_READ  = 2'b10,
        DDA_WRITE = 2'b11
    } dda_state_t;

    typedef struct packed {
        dda_state_t  state;
        logic [9:0]  ctrl;
        logic [31:0] srcPtr;
        logic [31:0] dstPtr;
        logic [23:0] count;
        logic [7:0]  function_code_register;
        logic        done;
        logic        errSrc;
        logic        errDst;
        logic [31:0] hold;
        logic [2:0]  off;
        logic        pending;
        logic        lastFlag;
        logic        wbAck;
        logic [31:0] wbDat;
        logic        busReq;
        logic        busGrantAck;
        logic        stb;
        logic        rnw;
        logic [31:0] adr;
        logic [31:0] dout;
        logic [2:0]  sz;
        logic [2:0]  fc;
        logic        topFc;
        logic        xack;
        logic        xdone;
    } dda_core_t;

    typedef struct packed {
        logic s1;
        logic s2;
    } dda_sync_t;

    typedef struct packed {
        logic prev;
        logic fired;
        logic pulse;
    } dda_det_t;
endpackage

// *** dda_regs.svh ***
// Register offsets, field positions and size codes of the DMA channel
`ifndef DDA_REGS_SVH
`define DDA_REGS_SVH
`define DDA_OFS_CTRL    8'h00
`define DDA_OFS_STATUS  8'h04
`define DDA_OFS_SRC     8'h08
`define DDA_OFS_DST     8'h0C
`define DDA_OFS_COUNT   8'h10
`define DDA_OFS_FC      8'h14
`define DDA_CTL_START   0
`define DDA_CTL_EXT     1
`define DDA_CTL_STEAL   2
`define DDA_CTL_SRCREQ  3
`define DDA_CTL_SSZ_LO  4
`define DDA_CTL_SSZ_HI  5
`define DDA_CTL_DSZ_LO  6
`define DDA_CTL_DSZ_HI  7
`define DDA_CTL_SINC    8
`define DDA_CTL_DINC    9
`define DDA_CTL_HI      9
`define DDA_ST_DONE     0
`define DDA_ST_ERRSRC   1
`define DDA_ST_ERRDST   2
`define DDA_SZ_LONG     2'h0
`define DDA_SZ_BYTE     2'h1
`define DDA_SZ_WORD     2'h2
`define DDA_BYTES_1     3'h1
`define DDA_BYTES_2     3'h2
`define DDA_BYTES_4     3'h4
`define DDA_MASK_1      32'h0000_00FF
`define DDA_MASK_2      32'h0000_FFFF
`define DDA_MASK_4      32'hFFFF_FFFF
`define DDA_ZERO_32     32'h0000_0000
`define DDA_ZERO_OFF    3'h0
`define DDA_MAX_CYCLES  3'h4
`endif

// *** dda_req_detect.sv ***
// Cycle-steal request recogniser: two consecutive high samples
module dda_req_detect (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic levelIn,
    output logic      pulseOut
);
    dda_pkg::dda_det_t st_reg;
    dda_pkg::dda_det_t st_next;

    always_comb begin
        st_next       = st_reg;
        st_next.prev  = levelIn;
        // One pulse per request, however long it is held
        st_next.pulse = levelIn & st_reg.prev & ~st_reg.fired;
        st_next.fired = levelIn & (st_reg.fired | st_reg.prev);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pulseOut = st_reg.pulse;
endmodule

// *** dda_sync.sv ***
// Two-stage falling-edge synchroniser for one pin
module dda_sync (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic pinIn,
    output logic      levelOut
);
    dda_pkg::dda_sync_t st_reg;
    dda_pkg::dda_sync_t st_next;

    always_comb begin
        st_next    = st_reg;
        st_next.s1 = pinIn;
        st_next.s2 = st_reg.s1;
    end

    // Falling edge gives the rising-edge logic half a cycle of margin
    always_ff @(negedge ref_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign levelOut = st_reg.s2;
endmodule

// *** tb_top.sv ***
// Self-checking bench of the DMA channel
`include "dda_regs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, rst, wbCyc, wbStb, wbWe, wbAck, busRequest;
    logic        busGrant, busGrantAck, sysStb, sysRnw, topFunctionCodeLine;
    logic        sysAck, transferRequestLine, transferAcknowledgeLine;
    logic        doneHandshakeOut, extMode, srcMode;
    logic [7:0]  wbAdr;
    logic [3:0]  wbSel;
    logic [31:0] wbDatIn, wbDatOut, sysAdr, sysDatOut, sysDatIn, rdVal;
    logic [2:0]  sysSize, sysFc;
    logic [1:0]  slow;
    logic [16:0] seed;
    logic [63:0] expQ[$];
    int          n_errors, tests_run, cycles;
    dda_channel u_dut (.*, .doneHandshakeIn(1'b0), .sysBerr(1'b0));
    dda_peer u_peer (.*);
    function automatic logic [31:0] f(input logic [31:0] a);
        return (a * 32'h0001_0003) ^ 32'hC3C3_0000;
    endfunction
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    // Released data lines show the inverse, never a stale copy
    assign sysDatIn = sysAck ? f(sysAdr) : ~f(sysAdr);
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        wbCyc   <= 1'b1;
        wbStb   <= 1'b1;
        wbWe    <= we;
        wbAdr   <= a;
        wbDatIn <= d;
        do @(posedge ref_clk); while (wbAck !== 1'b1);
        q = wbDatOut;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask
    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic run(input logic [31:0] ctl, input logic [31:0] src,
                       input logic [31:0] dst, input int cnt);
        logic [31:0] w;
        w = 32'h0000_0000;
        wb(1'b1, `DDA_OFS_CTRL, 32'h0000_0000, rdVal);
        wb(1'b1, `DDA_OFS_STATUS, 32'h0000_0007, rdVal);
        wb(1'b1, `DDA_OFS_SRC, src, rdVal);
        wb(1'b1, `DDA_OFS_DST, dst, rdVal);
        wb(1'b1, `DDA_OFS_COUNT, 32'(cnt), rdVal);
        seed = lfsr(seed);
        slow <= seed[1:0];
        if (ctl[5:4] == 2'h1) begin
            for (int k = 0; k < 4; k++)
                w = (w << 8) | (f(src + 32'(k)) & 32'h0000_00FF);
            expQ.push_back({dst, w});
        end else begin
            for (int k = 0; k < cnt; k += 4)
                expQ.push_back({dst + 32'(k), f(src + 32'(k))});
        end
        extMode = ctl[1];
        srcMode = ctl[3];
        wb(1'b1, `DDA_OFS_CTRL, ctl, rdVal);
        if (ctl[1]) begin
            repeat (20) @(posedge ref_clk);
            chk(32'(busRequest), 32'h0000_0000);
            transferRequestLine <= 1'b1;
        end
        rdVal = 32'h0000_0000;
        while (rdVal[0] !== 1'b1) begin
            // Steal peer pulses three cycles high, three low
            if (ctl[2]) transferRequestLine <= ~transferRequestLine;
            wb(1'b0, `DDA_OFS_STATUS, 32'h0, rdVal);
        end
        chk(rdVal, 32'h0000_0001);
        transferRequestLine <= 1'b0;
        wb(1'b0, `DDA_OFS_SRC, 32'h0000_0000, rdVal);
        chk(rdVal, src + (ctl[8] ? 32'(cnt) : 32'h0));
        wb(1'b0, `DDA_OFS_DST, 32'h0000_0000, rdVal);
        chk(rdVal, dst + (ctl[9] ? 32'(cnt) : 32'h0));
        wb(1'b0, `DDA_OFS_COUNT, 32'h0000_0000, rdVal);
        chk(rdVal, 32'h0000_0000);
        chk(32'(expQ.size()), 32'h0000_0000);
        $display("test done, control %h", ctl);
    endtask
    // Every write on the system bus is matched against the model queue
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles > 30000) begin
            n_errors++;
            tally_and_finish;
        end
        if (sysStb) chk(32'(topFunctionCodeLine), 32'h0000_0001);
        if (extMode && sysStb)
            chk(32'(transferAcknowledgeLine), 32'(sysRnw == srcMode));
        if (sysStb && sysAck && !sysRnw) begin
            if (expQ.size() == 0) begin
                chk(sysAdr, 32'hFFFF_FFFF);
            end else begin
                chk(sysAdr, expQ[0][63:32]);
                chk(sysDatOut, expQ[0][31:0]);
                void'(expQ.pop_front());
            end
        end
    end
    initial begin
        rst = 1'b1;
        {wbCyc, wbStb, wbWe, transferRequestLine, extMode} = 5'h00;
        srcMode = 1'b0;
        wbAdr = 8'h00;
        wbSel = 4'hF;
        wbDatIn = 32'h0000_0000;
        slow = 2'h0;
        seed = 17'd91263;
        {n_errors, tests_run, cycles} = '0;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        wb(1'b0, 8'h40, 32'h0000_0000, rdVal);
        chk(rdVal, 32'h0000_0000);
        run(32'h0000_0301, 32'h0000_0100, 32'h0000_0200, 8);
        run(32'h0000_0111, 32'h0000_0300, 32'h0000_0400, 4);
        run(32'h0000_030B, 32'h0000_0500, 32'h0000_0600, 8);
        run(32'h0000_0307, 32'h0000_0700, 32'h0000_0800, 8);
        tally_and_finish;
    end
endmodule
